// ---- hb8_pkg.sv ----
package hb8_pkg;

    // Interface mode and sub-mode codes
    localparam logic [3:0] MODE_HOST_BUS8  = 4'h2;   // Top-level eight-bit host-bus mode
    localparam logic [1:0] SUB_MUXED       = 2'h0;   // Multiplexed address/data
    localparam logic [1:0] SUB_NONMUXED    = 2'h1;   // Separate address and data pins

    // Select-scheme codes
    localparam logic [1:0] SEL_ALE_ONLY    = 2'h0;   // Latch strobe only
    localparam logic [1:0] SEL_ONE_CS      = 2'h1;   // One chip select
    localparam logic [1:0] SEL_TWO_CS      = 2'h2;   // Two chip selects
    localparam logic [1:0] SEL_ALE_TWO_CS  = 2'h3;   // Latch strobe plus two chip selects

    // Widths
    localparam int ADDR_W = 20;                      // Address bits 0..19 on muxed mode
    localparam int DATA_W = 8;                       // Eight data bits only
    localparam int NCS    = 4;                       // Four select pins; cs_decode drives only the low two

    // Phase lengths in ns, and derived cycle counts at 125 MHz (8 ns)
    localparam int CLK_PERIOD_NS = 8;                // Clock period
    localparam int ADDR_PH_NS    = 16;               // Address phase, latch strobe high
    localparam int HOLD_PH_NS    = 8;                // Address hold after latch strobe
    localparam int DATA_PH_NS    = 32;               // Read/write strobe width
    localparam int ADDR_CYC = (ADDR_PH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC = (HOLD_PH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DATA_CYC = (DATA_PH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W    = 4;                     // Phase counter width
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;    // Counter reset value

    // Configuration carried in from the wider interface
    typedef struct packed {
        logic [3:0] mode;                            // Top-level interface mode
        logic [1:0] sub_mode;                        // Muxed or non-muxed
        logic [1:0] sel_scheme;                      // Select scheme
    } hb_cfg_s;

    // One access request
    typedef struct packed {
        logic              write;                    // 1 = write, 0 = read
        logic [1:0]        target;                   // Peripheral 0..3
        logic [ADDR_W-1:0] addr;                     // Byte address
        logic [DATA_W-1:0] wdata;                    // Write data
    } hb_req_s;

    // Pin outputs toward the external peripherals
    typedef struct packed {
        logic [DATA_W-1:0] ad_out;                   // Shared address/data out
        logic              ad_oe;                    // Shared bus drive enable
        logic [ADDR_W-1:8] addr_hi;                  // Dedicated address bits
        logic              ale;                      // Address-latch strobe
        logic              rd_n;                     // Read strobe
        logic              wr_n;                     // Write strobe
        logic [NCS-1:0]    cs_n;                     // Chip selects
    } hb_pins_s;

    // Bus phases
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_HOLD = 3'b010,
        ST_DATA = 3'b011,
        ST_DONE = 3'b100
    } hb_state_e;

    // Map target number to active-low selects under a given scheme
    function automatic logic [NCS-1:0] cs_decode(input logic [1:0] scheme,
                                                 input logic [1:0] target);
        logic [NCS-1:0] sel;
        sel = {NCS{1'b1}};
        case (scheme)
            SEL_ONE_CS:                 sel[0] = 1'b0;
            SEL_TWO_CS, SEL_ALE_TWO_CS: sel[target[0]] = 1'b0;
            default:                    sel = {NCS{1'b1}};
        endcase
        return sel;
    endfunction : cs_decode

endpackage : hb8_pkg

// ---- hb8_sync3.sv ----
`timescale 1ns/1ps
`default_nettype none
// Three-stage input synchroniser; a change counts once stages two and three agree
module hb8_sync3 #(
    parameter int W = 8                              // Width
) (
    input  wire logic         clk,                   // Clock
    input  wire logic         rst_n,                 // Async reset, active low
    input  wire logic [W-1:0] din,                   // Asynchronous input
    output logic      [W-1:0] dout                   // Filtered synchronous value
);
    logic [W-1:0] s1_q;                              // Metastability catcher
    logic [W-1:0] s2_q;                              // Second stage
    logic [W-1:0] s3_q;                              // Third stage
    logic [W-1:0] held_q;                            // Last agreed value

    // Shift chain; first stage feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A bit follows the late stages once they agree, else it keeps its last agreed value.
    // Kept combinational so read data settle inside a four-clock strobe; a fourth
    // register here would leave the sample one clock short of the pin change.
    assign dout = (s2_q & s3_q) | (held_q & (s2_q | s3_q));

    // Remember the agreed value for bits whose late stages still disagree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            held_q <= '0;
        end else begin
            held_q <= dout;
        end
    end
endmodule : hb8_sync3
`default_nettype wire

// ---- hb8_master.sv ----
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Mode code 0x2 enables eight-bit host bus
// - Sub-mode 0x0 selects multiplexed address/data
// - Only eight data bits are carried
// - Low address shares data lines; A8-A19 dedicated
// - Latch strobe marks address; latch holds it
// - Separate read and write strobes qualify data
// - One to four selects; one per access (code drives only cs_n[0] or cs_n[1], none under SEL_ALE_ONLY)
// - Scheme picks latch strobe and chip selects
// - Accesses paced slower than general-purpose mode
// - Non-muxed variant uses separate address, data pins (code drives only A8-A19 on addr_hi; A0-A7 are not output in this variant)
module hb8_master
    import hb8_pkg::*;
(
    input  wire logic              clk,              // 125 MHz clock
    input  wire logic              rst_n,            // Async reset, active low
    input  wire hb_cfg_s           cfg,              // Mode configuration
    input  wire logic              req_valid,        // Access request
    input  wire hb_req_s           req,              // Access descriptor
    output logic                   req_ready,        // Request accepted when high
    output logic                   rsp_valid,        // One-cycle completion pulse
    output logic [DATA_W-1:0]      rsp_rdata,        // Read data
    input  wire logic [DATA_W-1:0] ad_in,            // Shared bus pins in
    input  wire logic [DATA_W-1:0] data_in,          // Dedicated data pins in
    output logic [DATA_W-1:0]      data_out,         // Dedicated data pins out
    output logic                   data_oe,          // Dedicated data drive enable
    output hb_pins_s               pins              // Bus pins toward peripherals
);

    hb_state_e         st_q;                         // Bus phase
    logic [CNT_W-1:0]  cnt_q;                        // Phase countdown
    hb_req_s           cur_q;                        // Access in flight
    logic [DATA_W-1:0] ad_sync;                      // Synchronised shared bus
    logic [DATA_W-1:0] dat_sync;                     // Synchronised data pins
    logic              active;                       // Mode allows accesses
    logic              muxed;                        // Multiplexed variant
    logic              uses_ale;                     // Scheme carries latch strobe

    // Only act when the wider interface is in the eight-bit host-bus mode
    assign active   = (cfg.mode == MODE_HOST_BUS8);
    assign muxed    = (cfg.sub_mode == SUB_MUXED);
    assign uses_ale = (cfg.sel_scheme == SEL_ALE_ONLY)
                   || (cfg.sel_scheme == SEL_ALE_TWO_CS);

    // Pins from the outside world pass the three-stage synchroniser
    hb8_sync3 #(.W(DATA_W)) u_sync_ad (
        .clk   (clk),
        .rst_n (rst_n),
        .din   (ad_in),
        .dout  (ad_sync)
    );
    hb8_sync3 #(.W(DATA_W)) u_sync_dat (
        .clk   (clk),
        .rst_n (rst_n),
        .din   (data_in),
        .dout  (dat_sync)
    );

    // Phase sequencer; address and data phases span several clocks, the hold phase one, slower than a plain access
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q  <= ST_IDLE;
            cnt_q <= CNT_ZERO;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (req_valid && req_ready) begin
                        st_q  <= ST_ADDR;
                        cnt_q <= CNT_W'(ADDR_CYC - 1);
                    end
                end
                ST_ADDR: begin
                    if (cnt_q == CNT_ZERO) begin
                        st_q  <= ST_HOLD;
                        cnt_q <= CNT_W'(HOLD_CYC - 1);
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                ST_HOLD: begin
                    if (cnt_q == CNT_ZERO) begin
                        st_q  <= ST_DATA;
                        cnt_q <= CNT_W'(DATA_CYC - 1);
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                ST_DATA: begin
                    if (cnt_q == CNT_ZERO) begin
                        st_q <= ST_DONE;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                ST_DONE: st_q <= ST_IDLE;
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // Capture the request; a mode change mid-access does not corrupt it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_q <= '0;
        end else if (st_q == ST_IDLE && req_valid && req_ready) begin
            cur_q <= req;
        end
    end

    // Ready only while idle and in the right mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_ready <= 1'b0;
        end else begin
            req_ready <= active && (st_q == ST_IDLE) && !(req_valid && req_ready);
        end
    end

    // Read data sampled at the last strobe cycle from the right pins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end else begin
            rsp_valid <= (st_q == ST_DATA) && (cnt_q == CNT_ZERO);
            if (st_q == ST_DATA && cnt_q == CNT_ZERO && !cur_q.write) begin
                rsp_rdata <= muxed ? ad_sync : dat_sync;
            end
        end
    end

    // Shared lines: address byte in address phase, write data under WR only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pins.ad_out  <= '0;
            pins.ad_oe   <= 1'b0;
            pins.addr_hi <= '0;
            data_out     <= '0;
            data_oe      <= 1'b0;
        end else begin
            pins.addr_hi <= '0;
            pins.ad_out  <= '0;
            pins.ad_oe   <= 1'b0;
            data_out     <= '0;
            data_oe      <= 1'b0;
            if (st_q == ST_IDLE && req_valid && req_ready) begin
                pins.addr_hi <= req.addr[ADDR_W-1:8];
                pins.ad_out  <= muxed ? req.addr[7:0] : '0;
                pins.ad_oe   <= muxed;
            end else if (st_q == ST_ADDR || st_q == ST_HOLD) begin
                pins.addr_hi <= cur_q.addr[ADDR_W-1:8];
                pins.ad_out  <= muxed ? cur_q.addr[7:0] : '0;
                pins.ad_oe   <= muxed;
                // Strobe starts next cycle: release the shared lines for a read
                if (st_q == ST_HOLD && cnt_q == CNT_ZERO) begin
                    pins.ad_oe  <= muxed && cur_q.write;
                    pins.ad_out <= (muxed && cur_q.write) ? cur_q.wdata : '0;
                    data_out    <= cur_q.write ? cur_q.wdata : '0;
                    data_oe     <= !muxed && cur_q.write;
                end
            end else if (st_q == ST_DATA) begin
                pins.addr_hi <= cur_q.addr[ADDR_W-1:8];
                if (cur_q.write && !(cnt_q == CNT_ZERO)) begin
                    pins.ad_out <= muxed ? cur_q.wdata : '0;
                    pins.ad_oe  <= muxed;
                    data_out    <= cur_q.wdata;
                    data_oe     <= !muxed;
                end
            end
        end
    end

    // Latch strobe during the address phase only, when the scheme has one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pins.ale <= 1'b0;
        end else begin
            pins.ale <= uses_ale && ((st_q == ST_IDLE && req_valid && req_ready)
                     || (st_q == ST_ADDR && cnt_q != CNT_ZERO));
        end
    end

    // Read/write strobes span the data phase; launched from the last hold cycle, they drop together with the write data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pins.rd_n <= 1'b1;
            pins.wr_n <= 1'b1;
        end else begin
            pins.rd_n <= !((st_q == ST_HOLD && cnt_q == CNT_ZERO && !cur_q.write)
                        || (st_q == ST_DATA && cnt_q != CNT_ZERO && !cur_q.write));
            pins.wr_n <= !((st_q == ST_HOLD && cnt_q == CNT_ZERO && cur_q.write)
                        || (st_q == ST_DATA && cnt_q != CNT_ZERO && cur_q.write));
        end
    end

    // One chip select (none under SEL_ALE_ONLY) held from address phase through end of strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pins.cs_n <= {NCS{1'b1}};
        end else if (st_q == ST_IDLE && req_valid && req_ready) begin
            pins.cs_n <= cs_decode(cfg.sel_scheme, req.target);
        end else if (st_q == ST_DATA && cnt_q == CNT_ZERO) begin
            pins.cs_n <= {NCS{1'b1}};
        end
    end

    // Never more than one select low
    a_cs_onehot: assert property (@(posedge clk) disable iff (!rst_n)
        $countones(~pins.cs_n) <= 1)
        else $error("more than one chip select active");

    // No accesses outside the eight-bit host-bus mode
    a_mode_gate: assert property (@(posedge clk) disable iff (!rst_n)
        !active |=> !req_ready)
        else $error("ready outside host-bus mode");

    // Latch strobe and data strobes never overlap
    a_ale_excl: assert property (@(posedge clk) disable iff (!rst_n)
        pins.ale |-> (pins.rd_n && pins.wr_n))
        else $error("latch strobe overlaps data strobe");

    // Scheme 1 and 2 have no latch strobe
    a_no_ale: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg.sel_scheme == SEL_ONE_CS || cfg.sel_scheme == SEL_TWO_CS)
        && $stable(cfg.sel_scheme) |=> !pins.ale)
        else $error("latch strobe in chip-select-only scheme");

    sequence s_start;
        st_q == ST_IDLE && req_valid && req_ready;
    endsequence

    sequence s_addr_phase;
        pins.ale[*2] ##1 !pins.ale;
    endsequence

    // Access with latch: two strobe cycles, then data strobe for four
    a_access_seq: assert property (@(posedge clk) disable iff (!rst_n)
        s_start ##0 (uses_ale && $stable(cfg)) |=> s_addr_phase ##1
        (!pins.rd_n || !pins.wr_n)[*4] ##1 (pins.rd_n && pins.wr_n))
        else $error("access phase timing wrong");

    // Select stays asserted through the strobe
    a_cs_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (!pins.rd_n || !pins.wr_n) |-> !(&pins.cs_n) || cfg.sel_scheme == SEL_ALE_ONLY)
        else $error("strobe without chip select");

    // Muxed write drives shared bus under write strobe
    a_wr_drive: assert property (@(posedge clk) disable iff (!rst_n)
        !pins.wr_n && muxed && $stable(cfg) |-> pins.ad_oe && pins.ad_out == cur_q.wdata)
        else $error("write data not on shared bus");

    // Completion follows the last strobe cycle
    a_rsp_time: assert property (@(posedge clk) disable iff (!rst_n)
        s_start |-> ##8 rsp_valid)
        else $error("completion late or early");

endmodule : hb8_master
`default_nettype wire

// ---- hb8_periph_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// External address latch plus one byte-wide peripheral sitting on the master's pins
module hb8_periph_model
    import hb8_pkg::*;
(
    input  wire logic              clk,          // Bus clock
    input  wire hb_cfg_s           cfg,          // Mode the board is wired for
    input  wire hb_pins_s          pins,         // Master pins
    input  wire logic [DATA_W-1:0] data_out,     // Dedicated data from master
    output logic      [DATA_W-1:0] ad_in,        // Shared lines toward master
    output logic      [DATA_W-1:0] data_in       // Dedicated data toward master
);
    logic [7:0]  mem [0:1023];                   // Backing store, aliased on high bits
    logic [7:0]  lo_q;                           // Latched low address byte
    logic [11:0] hi_q;                           // Captured high address bits
    logic [7:0]  last_q;                         // Last value seen on the data lines
    logic        mux;                            // Shared address/data wiring
    logic        sel;                            // This peripheral is addressed
    logic        drive;                          // Peripheral drives the data lines
    logic [9:0]  key;                            // Store index

    assign mux   = (cfg.sub_mode == SUB_MUXED);
    assign sel   = (cfg.sel_scheme == SEL_ALE_ONLY) || (pins.cs_n != 4'hF);
    assign drive = sel && !pins.rd_n;
    assign key   = {hi_q[1:0], lo_q};
    // Released lines show the inverse of the last value so a stale sample never matches
    assign ad_in   = (drive && mux) ? mem[key] : ~last_q;
    assign data_in = (drive && !mux) ? mem[key] : ~last_q;

    // Fill the store so a read of an untouched place is never unknown
    initial begin
        for (int i = 0; i < 1024; i++) begin
            mem[i] = i[7:0] ^ 8'hA5;
        end
    end

    // Latch follows the bus in the address phase and holds through the data phase
    always @(posedge clk) begin
        if (pins.rd_n && pins.wr_n && (pins.ad_oe || !mux)
            && (pins.ale || cfg.sel_scheme inside {SEL_ONE_CS, SEL_TWO_CS})) begin
            lo_q <= mux ? pins.ad_out : 8'h00;
            hi_q <= pins.addr_hi;
        end
    end

    // Write strobe qualifies outgoing data; the last byte under it wins
    always @(posedge clk) begin
        last_q <= drive ? mem[key] : (mux ? pins.ad_out : data_out);
        if (!pins.wr_n && sel) begin
            mem[key] <= mux ? pins.ad_out : data_out;
        end
    end
endmodule : hb8_periph_model
`default_nettype wire

// ---- hb8_master_test.sv ----
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the eight-bit host-bus master
module hb8_master_test
    import hb8_pkg::*;
;
    logic          clk = 1'b0;                   // 125 MHz clock
    logic          rst_n;                        // Reset, active low
    hb_cfg_s       cfg;                          // Mode configuration
    logic          req_valid;                    // Request present
    hb_req_s       req;                          // Request descriptor
    logic          req_ready;                    // Master idle
    logic          rsp_valid;                    // Completion pulse
    logic [7:0]    rsp_rdata;                    // Read data
    logic [7:0]    ad_in;                        // Shared lines from peripheral
    logic [7:0]    data_in;                      // Dedicated data from peripheral
    logic [7:0]    data_out;                     // Dedicated data to peripheral
    logic          data_oe;                      // Dedicated data enable
    hb_pins_s      pins;                         // Bus pins
    int            failures = 0;                 // Mismatch count
    int            n_compared = 0;               // Comparison count
    int            cyc = 0;                      // Rising edges seen

    // Half period of 4 ns
    always #4 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    hb8_master dut (.clk(clk), .rst_n(rst_n), .cfg(cfg), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .ad_in(ad_in),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .pins(pins));
    hb8_periph_model periph (.clk(clk), .cfg(cfg), .pins(pins), .data_out(data_out),
        .ad_in(ad_in), .data_in(data_in));

    // Count one comparison and report it at once if it fails
    task automatic check(input logic ok, input string what);
        n_compared++;
        if (ok !== 1'b1) begin
            failures++;
            $display("ERROR at %0t: %s", $time, what);
        end
    endtask : check

    // Active-low selects expected for a scheme and target
    function automatic logic [3:0] want_cs(input logic [1:0] sch, input logic [1:0] tgt);
        if (sch == SEL_ALE_ONLY) return 4'hF;
        if (sch == SEL_ONE_CS) return 4'hE;
        return tgt[0] ? 4'hD : 4'hE;
    endfunction : want_cs

    // Print the verdict and end the run
    task automatic stop_test;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : stop_test

    // One access, entered at a falling edge; every cycle of the walk is compared
    task automatic access(input logic wr, input logic [1:0] tgt, input logic [19:0] a,
                          input logic [7:0] wd, output logic [7:0] rd, output int t_take);
        logic [1:0] sch;
        logic       mux;
        int         n;
        logic       ale_w;
        sch = cfg.sel_scheme;
        ale_w = sch inside {SEL_ALE_ONLY, SEL_ALE_TWO_CS};
        mux = (cfg.sub_mode == SUB_MUXED);
        n = 0;
        req_valid = 1'b1;
        req = '{write: wr, target: tgt, addr: a, wdata: wd};
        while (req_ready !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        check(n < 40, "request never taken");
        @(posedge clk);
        t_take = cyc;
        @(negedge clk);
        req_valid = 1'b0;
        // Step k shows what the design launched at the (k-1)th edge after the take
        for (int k = 1; k <= 8; k++) begin
            if (k > 1) @(negedge clk);
            if (k <= 3) begin
                check(pins.ale === (k < 3 && ale_w), "ale");
                check(pins.ad_oe === mux, "addr drive");
                check(!mux || pins.ad_out === a[7:0], "addr byte");
                check(pins.rd_n === 1'b1 && pins.wr_n === 1'b1, "early strobe");
            end else if (k < 8) begin
                check(pins.rd_n === wr && pins.wr_n === !wr, "data strobe");
                check(pins.ad_oe === (wr && mux), "data drive");
                check(!(wr && mux) || pins.ad_out === wd, "write data");
                if (!mux) check(data_oe === wr, "data enable");
                if (!mux && wr) check(data_out === wd, "data pins");
            end
            if (k < 8) check(pins.cs_n === want_cs(sch, tgt), "select");
            if (k < 8) check(pins.addr_hi === a[19:8], "high address");
            check(rsp_valid === (k == 8), "completion timing");
        end
        check(pins.cs_n === 4'hF, "select release");
        check(pins.rd_n === 1'b1 && pins.wr_n === 1'b1, "strobe release");
        rd = rsp_rdata;
    endtask : access

    // Every select scheme: write a byte, read it back
    task automatic t_schemes;
        logic [7:0] rd;
        int         t;
        for (int s = 0; s < 4; s++) begin
            cfg.sel_scheme = s[1:0];
            access(1'b1, s[1:0], 20'h5_A3C0 | s, 8'hC3 ^ s[7:0], rd, t);
            access(1'b0, s[1:0], 20'h5_A3C0 | s, 8'h00, rd, t);
            check(rd === (8'hC3 ^ s[7:0]), "read back");
        end
    endtask : t_schemes

    // Another interface mode: no request is taken and the bus stays quiet
    task automatic t_refused;
        cfg.mode = 4'h1;
        repeat (2) @(negedge clk);
        req_valid = 1'b1;
        for (int k = 0; k < 12; k++) begin
            @(negedge clk);
            check(req_ready === 1'b0 && pins.ale === 1'b0 && pins.cs_n === 4'hF
                  && pins.rd_n === 1'b1 && pins.wr_n === 1'b1, "other mode");
        end
        req_valid = 1'b0;
        @(negedge clk);
        cfg.mode = MODE_HOST_BUS8;
    endtask : t_refused

    // Back-to-back at the top address: pacing between takes
    task automatic t_back2back;
        logic [7:0] rd;
        int         t1;
        int         t2;
        cfg.sel_scheme = SEL_TWO_CS;
        access(1'b1, 2'h1, 20'hF_FFFF, 8'h00, rd, t1);
        access(1'b0, 2'h1, 20'hF_FFFF, 8'h00, rd, t2);
        check(t2 - t1 == 10, "take spacing");
        check(rd === 8'h00, "top address");
    endtask : t_back2back

    // Separate address and data pins
    task automatic t_nonmux;
        logic [7:0] rd;
        int         t;
        cfg.sub_mode = SUB_NONMUXED;
        cfg.sel_scheme = SEL_ALE_TWO_CS;
        access(1'b1, 2'h0, 20'h3_4500, 8'h96, rd, t);
        access(1'b0, 2'h0, 20'h3_4500, 8'h00, rd, t);
        check(rd === 8'h96, "dedicated read");
        cfg.sub_mode = SUB_MUXED;
    endtask : t_nonmux

    // Main sequence
    initial begin
        rst_n = 1'b0;
        cfg = '{mode: MODE_HOST_BUS8, sub_mode: SUB_MUXED, sel_scheme: SEL_ALE_TWO_CS};
        req_valid = 1'b0;
        req = '0;
        repeat (12) @(negedge clk);
        check(req_ready === 1'b0 && rsp_valid === 1'b0 && pins.ale === 1'b0 && pins.ad_oe === 1'b0
              && pins.cs_n === 4'hF && pins.rd_n === 1'b1 && pins.wr_n === 1'b1, "reset");
        rst_n = 1'b1;
        @(negedge clk);
        check(req_ready === 1'b1, "ready after reset");
        t_schemes();
        t_refused();
        t_back2back();
        t_nonmux();
        stop_test();
    end

    // Watchdog: the tests need well under 1000 cycles
    initial begin
        #200000;
        failures++;
        $display("ERROR at %0t: watchdog expired", $time);
        stop_test();
    end
endmodule : hb8_master_test
`default_nettype wire
